// ### design/ecss_pkg.sv
// package for the external clock source start-up block
package ecss_pkg;
  // reset source configuration codes
  localparam logic [2:0] RST_EXT = 3'h7;
  localparam logic [2:0] RST_HF1M = 3'h6;
  localparam logic [2:0] RST_LF = 3'h5;
  localparam logic [2:0] RST_SEC = 3'h4;
  localparam logic [2:0] RST_EXTPLL = 3'h2;
  localparam logic [2:0] RST_HF32M = 3'h0;
  // external mode configuration codes
  localparam logic [2:0] EXT_LOGIC_HIGH = 3'h0;
  localparam logic [2:0] EXT_LOGIC_LOW = 3'h1;
  localparam logic [2:0] EXT_XTAL_HIGH = 3'h2;
  localparam logic [2:0] EXT_XTAL_MED = 3'h4;
  localparam logic [2:0] EXT_XTAL_LOW = 3'h5;
  // start-up count of oscillator periods
  localparam int STARTUP_PERIODS = 1024;
  localparam logic [10:0] STARTUP_DONE = 11'h400;
  // reset values of run-time fields
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic [3:0] DIV_HF1M = 4'h2;
  localparam logic [2:0] FRQ_RESET = 3'h2;
  localparam logic [2:0] FRQ_32M = 3'h5;
  // register offsets on the plain port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_FREQ = 4'h2;
  localparam logic [3:0] REG_SEC = 4'h3;
  // control fields field positions
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int SEC_DRIVE_BIT = 0;
  localparam int SEC_EN_BIT = 1;
  // analog control bundle
  typedef struct packed {
    logic pll_en;
    logic [1:0] amp_gain;
    logic ext_high_power;
    logic sec_en;
    logic sec_high_power;
    logic [2:0] freq_sel;
  } ecss_ana_t;
endpackage

// ### design/ecss_clock_source.sv
// external clock source start-up, selection and clock-out routing
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Behaviour
// R1: fuse low drives instruction clock, system clock over four, onto output pin.
// R2: fuse high releases the output pin for general-purpose use.
// R3: logic-level clock mode skips the start-up counter entirely.
// R4: logic is fully static; a stopped clock simply freezes all state.
// R5: crystal modes count 1024 primary periods after reset or wake.
// R6: primary count completion sets the external ready flag.
// R7: secondary oscillator counts 1024 secondary periods then sets its ready flag.
// R8: secondary drive select 0 is low power, 1 high power.
// R9: software disables the secondary oscillator before changing its drive.
// R10: multiplier enabled whenever external-with-multiplier is selected.
// R11: external source used by reset fuses or run-time request.
// R12: chosen source is post-scaled by the divider request field.
// R13: fast internal frequency follows the internal frequency select register.
// R14: slow internal oscillator is a fixed nominal 31 kHz source.
// R15: crystal modes select low, medium or high amplifier gain.
// R16: secondary oscillator active when selected by fuse or run-time request.
// R17: logic-level clock mode offers high-power and low-power drive.
// R18: reset source fuse picks source after reset per the coded table.
// R19: switch allow fuse low makes writes to source and divider ignored.
// R20: ready flag cleared when a count starts, kept clear until done.
module ecss_clock_source (
  input wire logic sys_clk_i, // system clock, 100 MHz
  input wire logic rst_i, // asynchronous reset, active high
  input wire logic clk_en_i, // clock enable, freezes all state when low
  input wire logic wake_i, // wake from sleep pulse
  input wire logic [2:0] reset_source_fuse_i, // reset source configuration
  input wire logic [2:0] external_mode_fuse_i, // external mode configuration
  input wire logic clock_out_disable_fuse_i, // clock-out disable
  input wire logic switch_allow_fuse_i, // run-time switching allowed
  input wire logic primary_in_pin_i, // primary oscillator input
  input wire logic secondary_in_pin_i, // secondary oscillator input
  input wire logic gpio_out_i, // general-purpose value for output pin
  input wire logic gpio_oe_i, // general-purpose enable for output pin
  input wire logic [3:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, one cycle after strobe
  output logic primary_out_pin_o, // output pin value
  output logic primary_out_pin_oe_o, // output pin enable
  output logic [2:0] cur_source_o, // active source code
  output logic [3:0] cur_div_o, // active post-scale divider
  output ecss_pkg::ecss_ana_t ana_o, // oscillator analog controls
  output logic external_ready_flag_o, // external oscillator ready
  output logic secondary_ready_flag_o // secondary oscillator ready
);
  logic [1:0] pri_sync, sec_sync;
  logic pri_prev, sec_prev;
  logic [10:0] pri_cnt, sec_cnt;
  logic [2:0] src, freq;
  logic [3:0] div;
  logic sec_drive, sec_en, started;
  logic [1:0] icnt;
  logic [7:0] next_rdata;
  wire pri_edge = pri_sync[1] & ~pri_prev;
  wire sec_edge = sec_sync[1] & ~sec_prev;
  // decode of configuration and bus
  wire ext_logic = (external_mode_fuse_i == ecss_pkg::EXT_LOGIC_HIGH) ||
                   (external_mode_fuse_i == ecss_pkg::EXT_LOGIC_LOW);
  wire ext_used = (src == ecss_pkg::RST_EXT) || (src == ecss_pkg::RST_EXTPLL);
  wire sec_used = (src == ecss_pkg::RST_SEC) || sec_en;
  wire wr_ctrl = wr_i && addr_i == ecss_pkg::REG_CTRL && switch_allow_fuse_i;
  wire wr_freq = wr_i && addr_i == ecss_pkg::REG_FREQ;
  wire wr_sec = wr_i && addr_i == ecss_pkg::REG_SEC;
  wire restart = ~started | wake_i;
  wire [2:0] rst_src = (reset_source_fuse_i == ecss_pkg::RST_HF32M) ? ecss_pkg::RST_HF1M
                       : reset_source_fuse_i;
  wire [3:0] rst_div = (reset_source_fuse_i == ecss_pkg::RST_HF1M) ? ecss_pkg::DIV_HF1M
                       : ecss_pkg::DIV_RESET;
  wire [2:0] rst_frq = (reset_source_fuse_i == ecss_pkg::RST_HF32M) ? ecss_pkg::FRQ_32M
                       : ecss_pkg::FRQ_RESET;

  // pin synchronisers, first stage read only by second
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pri_sync <= 2'h0;
      sec_sync <= 2'h0;
      pri_prev <= 1'b0;
      sec_prev <= 1'b0;
    end else if (clk_en_i) begin
      pri_sync <= {pri_sync[0], primary_in_pin_i};
      sec_sync <= {sec_sync[0], secondary_in_pin_i};
      pri_prev <= pri_sync[1];
      sec_prev <= sec_sync[1];
    end
  end

  // R4 static state: everything freezes while clock enable is low
  // R14 R18 reset fuse loaded at first enabled edge after release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      started <= 1'b0;
      src <= ecss_pkg::RST_HF1M;
      div <= ecss_pkg::DIV_RESET;
      freq <= ecss_pkg::FRQ_RESET;
      sec_drive <= 1'b0;
      sec_en <= 1'b0;
    end else if (clk_en_i) begin
      started <= 1'b1;
      if (!started) begin
        src <= rst_src;
        div <= rst_div;
        freq <= rst_frq;
      // R19 switch lock: writes dropped when fuse low
      end else if (wr_ctrl) begin
        src <= wdata_i[ecss_pkg::CTRL_SRC_LSB +: 3];
        div <= wdata_i[ecss_pkg::CTRL_DIV_LSB +: 4];
      end
      // R13 frequency select register
      if (started && wr_freq) begin
        freq <= wdata_i[2:0];
      end
      // R8 R9 drive bit only changes while the sec_en enable bit is clear
      if (started && wr_sec) begin
        sec_en <= wdata_i[ecss_pkg::SEC_EN_BIT];
        if (!sec_en) begin
          sec_drive <= wdata_i[ecss_pkg::SEC_DRIVE_BIT];
        end
      end
    end
  end

  // R5 R6 R20 primary start-up counter; R3 bypass in logic-level mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pri_cnt <= 11'h0;
      external_ready_flag_o <= 1'b0;
    end else if (clk_en_i) begin
      if (restart) begin
        pri_cnt <= 11'h0;
        external_ready_flag_o <= ext_logic;
      end else if (ext_logic) begin
        external_ready_flag_o <= 1'b1;
      end else if (pri_cnt != ecss_pkg::STARTUP_DONE) begin
        if (pri_edge) begin
          pri_cnt <= pri_cnt + 11'h1;
        end
        external_ready_flag_o <= 1'b0;
      end else begin
        external_ready_flag_o <= 1'b1;
      end
    end
  end

  // R7 R20 secondary start-up counter, restarts when oscillator off
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_cnt <= 11'h0;
      secondary_ready_flag_o <= 1'b0;
    end else if (clk_en_i) begin
      if (restart || !sec_used) begin
        sec_cnt <= 11'h0;
        secondary_ready_flag_o <= 1'b0;
      end else if (sec_cnt != ecss_pkg::STARTUP_DONE) begin
        if (sec_edge) begin
          sec_cnt <= sec_cnt + 11'h1;
        end
      end else begin
        secondary_ready_flag_o <= 1'b1;
      end
    end
  end

  // R1 R2 instruction clock divider and output pin routing
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      icnt <= 2'h0;
      primary_out_pin_o <= 1'b0;
      primary_out_pin_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      icnt <= icnt + 2'h1;
      primary_out_pin_o <= clock_out_disable_fuse_i ? gpio_out_i : icnt[1];
      primary_out_pin_oe_o <= clock_out_disable_fuse_i ? gpio_oe_i : 1'b1;
    end
  end

  // register read mux; unmapped reads return zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      ecss_pkg::REG_CTRL: next_rdata = {1'b0, src, div};
      ecss_pkg::REG_STAT: next_rdata = {6'h00, secondary_ready_flag_o, external_ready_flag_o};
      ecss_pkg::REG_FREQ: next_rdata = {5'h00, freq};
      ecss_pkg::REG_SEC: next_rdata = {6'h00, sec_en, sec_drive};
      default: next_rdata = 8'h00;
    endcase
  end

  // R10 R11 R12 R15 R16 R17 source, divider and analog controls
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      cur_source_o <= ecss_pkg::RST_HF1M;
      cur_div_o <= ecss_pkg::DIV_RESET;
      ana_o <= '0;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
      cur_source_o <= src;
      cur_div_o <= div;
      ana_o.pll_en <= (src == ecss_pkg::RST_EXTPLL);
      ana_o.amp_gain <= !ext_used || ext_logic ? 2'h0 :
                        external_mode_fuse_i == ecss_pkg::EXT_XTAL_HIGH ? 2'h3 :
                        external_mode_fuse_i == ecss_pkg::EXT_XTAL_MED ? 2'h2 : 2'h1;
      ana_o.ext_high_power <= external_mode_fuse_i == ecss_pkg::EXT_LOGIC_HIGH;
      ana_o.sec_en <= sec_used;
      ana_o.sec_high_power <= sec_drive;
      ana_o.freq_sel <= freq;
    end
  end

  // R10 multiplier follows selection
  a_pll_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R10
    !rst_i && clk_en_i |=> ana_o.pll_en == ($past(src) == ecss_pkg::RST_EXTPLL))
    else $error("pll enable wrong");
  // R6 ready only after full count or in logic-level mode
  a_ext_ready: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R6
    $rose(external_ready_flag_o) |-> ext_logic || pri_cnt == ecss_pkg::STARTUP_DONE)
    else $error("external ready early");
  // R7 secondary ready only after full count
  a_sec_ready: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R7
    secondary_ready_flag_o |-> sec_cnt == ecss_pkg::STARTUP_DONE)
    else $error("secondary ready early");
  // R19 locked writes change nothing
  a_switch_lock: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R19
    started && clk_en_i && !switch_allow_fuse_i |=> $stable(src) && $stable(div))
    else $error("locked switch changed");
  // R1 clock-out drives enable
  a_clkout_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R1
    !rst_i && clk_en_i && !clock_out_disable_fuse_i |=> primary_out_pin_oe_o)
    else $error("clock out not driven");
  sequence s_ext_not_ready;
    !external_ready_flag_o;
  endsequence
  // R20 restart clears ready
  a_ready_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R20
    clk_en_i && wake_i && !ext_logic |=> s_ext_not_ready ##1 s_ext_not_ready)
    else $error("ready not cleared");
  // R4 frozen while disabled
  a_static_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
    !clk_en_i |=> $stable(pri_cnt) && $stable(src) && $stable(rdata_o))
    else $error("state moved while frozen");
  // R3 logic mode ready at once
  a_ext_bypass: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R3
    !rst_i && clk_en_i && ext_logic |=> external_ready_flag_o)
    else $error("bypass not immediate");
  // R1 instruction clock on pin
  a_clkout_wave: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R1
    !rst_i && clk_en_i && !clock_out_disable_fuse_i |=> primary_out_pin_o == $past(icnt[1]))
    else $error("clock out wave wrong");
  // R2 gpio owns released pin
  a_clkout_gpio: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R2
    !rst_i && clk_en_i && clock_out_disable_fuse_i |=>
    primary_out_pin_o == $past(gpio_out_i) && primary_out_pin_oe_o == $past(gpio_oe_i))
    else $error("released pin not gpio");
  // R5 no ready while counting
  a_pri_waiting: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R5
    !rst_i && clk_en_i && !restart && !ext_logic && pri_cnt != ecss_pkg::STARTUP_DONE |=>
    !external_ready_flag_o)
    else $error("external ready during count");
  // R7 no secondary ready while counting
  a_sec_waiting: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R7
    !rst_i && clk_en_i && !restart && sec_used && sec_cnt != ecss_pkg::STARTUP_DONE |=>
    !secondary_ready_flag_o)
    else $error("secondary ready during count");
  // R8 drive select reaches amplifier
  a_drive_map: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R8
    !rst_i && clk_en_i |=> ana_o.sec_high_power == $past(sec_drive))
    else $error("drive select not applied");
  // R8 drive held while running
  a_drive_locked: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R8
    !rst_i && clk_en_i && sec_en |=> $stable(sec_drive))
    else $error("drive changed while enabled");
  // R11 active source follows request
  a_source_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R11
    !rst_i && clk_en_i |=> cur_source_o == $past(src))
    else $error("source not applied");
  // R12 divider follows request
  a_div_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R12
    !rst_i && clk_en_i |=> cur_div_o == $past(div))
    else $error("divider not applied");
  // R13 frequency select applied
  a_freq_follows: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R13
    !rst_i && clk_en_i |=> ana_o.freq_sel == $past(freq))
    else $error("frequency not applied");
  // R13 frequency write lands
  a_freq_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R13
    !rst_i && clk_en_i && started && wr_freq |=> freq == $past(wdata_i[2:0]))
    else $error("frequency write lost");
  // R15 high gain crystal
  a_gain_high: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
    !rst_i && clk_en_i && ext_used && external_mode_fuse_i == ecss_pkg::EXT_XTAL_HIGH |=>
    ana_o.amp_gain == 2'h3)
    else $error("high gain not set");
  // R15 low gain crystal
  a_gain_low: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
    !rst_i && clk_en_i && ext_used && external_mode_fuse_i == ecss_pkg::EXT_XTAL_LOW |=>
    ana_o.amp_gain == 2'h1)
    else $error("low gain not set");
  // R16 secondary powered when selected
  a_sec_active: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R16
    !rst_i && clk_en_i && src == ecss_pkg::RST_SEC |=> ana_o.sec_en)
    else $error("secondary not powered");
  // R17 logic clock power variant
  a_logic_power: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R17
    !rst_i && clk_en_i |=>
    ana_o.ext_high_power == ($past(external_mode_fuse_i) == ecss_pkg::EXT_LOGIC_HIGH))
    else $error("logic clock power wrong");
  // R18 fuses loaded after release
  a_reset_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R18
    !rst_i && clk_en_i && !started |=> src == $past(rst_src) && div == $past(rst_div))
    else $error("reset source not loaded");
  // R20 wake clears secondary ready
  a_sec_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R20
    !rst_i && clk_en_i && wake_i |=> !secondary_ready_flag_o)
    else $error("secondary ready not cleared");
endmodule

// ### tb/ecss_osc_model.sv
// oscillator model driving the primary and secondary input pins
`timescale 1ns/100ps
module ecss_osc_model #(
  parameter real PRI_HALF = 13.0, // primary half period in ns
  parameter real SEC_HALF = 37.0 // secondary half period in ns
) (
  input wire logic sec_en_i, // secondary amplifier powered
  output logic pri_o, // primary oscillator output
  output logic sec_o // secondary oscillator output
);
  // primary source swings freely, phase unrelated to the system clock
  initial begin
    pri_o = 1'b0;
    forever #(PRI_HALF) pri_o = ~pri_o;
  end
  // secondary crystal only swings while powered, else it rests low
  initial begin
    sec_o = 1'b0;
    forever begin
      #(SEC_HALF);
      sec_o = sec_en_i ? ~sec_o : 1'b0;
    end
  end
endmodule

// ### tb/ecss_clock_source_test.sv
// self-checking bench for the clock source start-up block
`timescale 1ns/100ps
module ecss_clock_source_test;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clk_en = 1'b1, wake = 1'b0, cod = 1'b0, swa = 1'b1, gout = 1'b0, goe = 1'b0;
  logic [2:0] rsf = ecss_pkg::RST_EXT;
  logic [2:0] emf = ecss_pkg::EXT_XTAL_HIGH;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic wr = 1'b0, rd = 1'b0, pri, sec, pin, oe, xrdy, srdy, p0;
  logic [2:0] src;
  logic [3:0] div;
  ecss_pkg::ecss_ana_t ana;
  int n_fail = 0;
  int total_checks = 0;
  // 100 MHz system clock
  always #5 sys_clk_i = ~sys_clk_i;
  ecss_clock_source ecss_clock_source_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .clk_en_i(clk_en), .wake_i(wake), .reset_source_fuse_i(rsf), .external_mode_fuse_i(emf),
    .clock_out_disable_fuse_i(cod), .switch_allow_fuse_i(swa), .primary_in_pin_i(pri),
    .secondary_in_pin_i(sec), .gpio_out_i(gout), .gpio_oe_i(goe), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .primary_out_pin_o(pin),
    .primary_out_pin_oe_o(oe), .cur_source_o(src), .cur_div_o(div), .ana_o(ana),
    .external_ready_flag_o(xrdy), .secondary_ready_flag_o(srdy));
  ecss_osc_model ecss_osc_model_inst (.sec_en_i(ana.sec_en), .pri_o(pri), .sec_o(sec));
  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait n edges, then settle to the falling edge for sampling
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task do_reset;
    @(posedge sys_clk_i) rst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    cyc(3);
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge sys_clk_i) wr <= 1'b0;
    cyc(3);
  endtask
  task rreg(input logic [3:0] a);
    @(posedge sys_clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge sys_clk_i) rd <= 1'b0;
    @(negedge sys_clk_i) v = rdata;
  endtask
  task t_modes;
    logic [2:0] m [4];
    logic [7:0] g [4];
    m = '{ecss_pkg::EXT_XTAL_MED, ecss_pkg::EXT_XTAL_LOW, ecss_pkg::EXT_LOGIC_HIGH,
      ecss_pkg::EXT_LOGIC_LOW};
    g = '{8'h02, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i) emf <= m[i];
      do_reset;
      chk(8'(ana.amp_gain), g[i]);
      chk(8'(xrdy), 8'(i / 2));
      if (i > 1) chk(8'(ana.ext_high_power), 8'(3 - i));
    end
    $display("test modes done");
  endtask
  task t_crystal;
    @(posedge sys_clk_i) emf <= ecss_pkg::EXT_XTAL_HIGH;
    do_reset;
    chk(8'(xrdy), 8'h00);
    chk(8'(ana.amp_gain), 8'h03);
    cyc(2450);
    chk(8'(xrdy), 8'h00);
    cyc(350);
    chk(8'(xrdy), 8'h01);
    rreg(ecss_pkg::REG_STAT);
    chk(v, 8'h01);
    @(posedge sys_clk_i) wake <= 1'b1;
    @(posedge sys_clk_i) wake <= 1'b0;
    cyc(3);
    chk(8'(xrdy), 8'h00);
    cyc(2800);
    chk(8'(xrdy), 8'h01);
    $display("test crystal done");
  endtask
  task t_clkout;
    @(posedge sys_clk_i) rsf <= ecss_pkg::RST_HF1M;
    do_reset;
    chk(8'(div), 8'(ecss_pkg::DIV_HF1M));
    chk(8'(oe), 8'h01);
    p0 = pin;
    cyc(2);
    chk(8'(pin), 8'(!p0));
    cyc(2);
    chk(8'(pin), 8'(p0));
    @(posedge sys_clk_i) clk_en <= 1'b0;
    cyc(1);
    p0 = pin;
    cyc(3);
    chk(8'(pin), 8'(p0));
    @(posedge sys_clk_i) begin clk_en <= 1'b1; cod <= 1'b1; end
    do_reset;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i) begin gout <= 1'(i); goe <= 1'(1 - i); end
      cyc(3);
      chk(8'(pin), 8'(i));
      chk(8'(oe), 8'(1 - i));
    end
    $display("test clock out done");
  endtask
  task t_switch;
    @(posedge sys_clk_i) rsf <= ecss_pkg::RST_HF32M;
    do_reset;
    chk(8'(src), 8'h06);
    chk(8'(ana.freq_sel), 8'(ecss_pkg::FRQ_32M));
    wreg(ecss_pkg::REG_FREQ, 8'h03);
    chk(8'(ana.freq_sel), 8'h03);
    wreg(ecss_pkg::REG_CTRL, {1'b0, ecss_pkg::RST_EXTPLL, 4'h3});
    chk(8'(src), 8'h02);
    chk(8'(div), 8'h03);
    chk(8'(ana.pll_en), 8'h01);
    rreg(ecss_pkg::REG_CTRL);
    chk(v, 8'h23);
    @(posedge sys_clk_i) begin swa <= 1'b0; rsf <= ecss_pkg::RST_EXTPLL; end
    do_reset;
    chk(8'(ana.pll_en), 8'h01);
    wreg(ecss_pkg::REG_CTRL, {1'b0, ecss_pkg::RST_LF, 4'h1});
    chk(8'(src), 8'h02);
    chk(8'(div), 8'h00);
    rreg(ecss_pkg::REG_CTRL);
    chk(v, 8'h20);
    @(posedge sys_clk_i) rsf <= ecss_pkg::RST_LF;
    do_reset;
    chk(8'(src), 8'(ecss_pkg::RST_LF));
    chk(8'(ana.freq_sel), 8'(ecss_pkg::FRQ_RESET));
    $display("test switch done");
  endtask
  task t_secondary;
    @(posedge sys_clk_i) begin swa <= 1'b1; rsf <= ecss_pkg::RST_SEC; end
    do_reset;
    chk(8'(src), 8'(ecss_pkg::RST_SEC));
    chk(8'(ana.sec_en), 8'h01);
    @(posedge sys_clk_i) rsf <= ecss_pkg::RST_EXT;
    do_reset;
    chk(8'(srdy), 8'h00);
    wreg(ecss_pkg::REG_SEC, 8'h01);
    wreg(ecss_pkg::REG_SEC, 8'h03);
    chk(8'(ana.sec_high_power), 8'h01);
    chk(8'(ana.sec_en), 8'h01);
    wreg(ecss_pkg::REG_SEC, 8'h02);
    chk(8'(ana.sec_high_power), 8'h01);
    cyc(7000);
    chk(8'(srdy), 8'h00);
    cyc(1000);
    chk(8'(srdy), 8'h01);
    wreg(ecss_pkg::REG_SEC, 8'h00);
    wreg(ecss_pkg::REG_SEC, 8'h00);
    chk(8'(ana.sec_high_power), 8'h00);
    $display("test secondary done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset;
    t_modes;
    t_crystal;
    t_clkout;
    t_switch;
    t_secondary;
    close_out;
  end
  // watchdog, well past the expected run length
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule
